// >>> inc/blocking_defs.vh
`ifndef BLOCKING_DEFS_VH
`define BLOCKING_DEFS_VH

// ==========================================================
// Register byte offsets on the APB bus.
// ==========================================================
`define OFS_CTRL 8'h00
`define OFS_SEL_A 8'h04
`define OFS_SEL_B 8'h08
`define OFS_MOD_EN 8'h0C
`define OFS_EXT_PERMIT 8'h10
`define OFS_PERM_TRIP 8'h14
`define OFS_TRIP_PERMIT 8'h18
`define OFS_RI_PERMIT 8'h1C
`define OFS_REL_DELAY 8'h20
`define OFS_TRIP_DELAY 8'h24
`define OFS_STATUS 8'h28

// ==========================================================
// Field positions.
// ==========================================================
`define CTRL_GLOBAL_EN 0
`define CTRL_GLOBAL_PERMIT 1
`define SEL_W 5
`define SEL_FIELD_STRIDE 8
`define SEL_COUNT 5
`define SEL_IDX_GLOBAL 0
`define SEL_IDX_SLOT_A 1
`define SEL_IDX_SLOT_B 2
`define SEL_IDX_TRIP 3
`define SEL_IDX_RI 4
`define STAT_MOD_POS 0
`define STAT_TRIP_POS 8
`define STAT_GLOBAL_POS 16
`define STAT_TIMER_POS 17
`define DELAY_W 16

// ==========================================================
// Reset values.
// ==========================================================
`define CTRL_RESET 2'h1
`define SEL_RESET 5'h00
`define DELAY_RESET 16'h0000

`endif

// >>> tb/blocking_assertions.sv
// ======
// Port checker for the blocking logic.
// ======
module blocking_assertions #(
   parameter N = 8
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Bus handshake.
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // Protection path.
   input wire [N-1:0] start_in,
   input wire [N-1:0] trip_in,
   input wire [N-1:0] start_out,
   input wire [N-1:0] trip_out,
   input wire [N-1:0] module_blocked,
   input wire [N-1:0] trip_blocked
);
   timeunit 1ns;
   timeprecision 1ns;
   // All checks run on the bus clock and pause in reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // A setup cycle is answered in the next cycle, once.
   a_setup_answered: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without answer");
   // Every module leaves reset switched off.
   a_reset_blocks: assert property (
      $rose(presetn) |-> &module_blocked)
      else $error("module free right after reset");
   // Gated outputs never pass a blocked stage.
   a_start_blocked: assert property (
      !(start_out & module_blocked))
      else $error("start passed a blocked module");
   a_trip_blocked: assert property (
      !(trip_out & trip_blocked))
      else $error("trip passed a trip block");
   a_trip_module: assert property (
      !(trip_out & module_blocked))
      else $error("trip passed a blocked module");
   // Gated outputs only follow a raw element output.
   a_start_cause: assert property (
      !(start_out & ~$past(start_in)))
      else $error("start without element start");
   a_trip_cause: assert property (
      !(trip_out & ~$past(trip_in)))
      else $error("trip without element trip");
   // Main scenarios.
   c_trip: cover property (|trip_out);
   c_part: cover property (|module_blocked && !(&module_blocked));
   c_error: cover property (pslverr);
endmodule

// >>> tb/field_model.sv
// ======
// Protection elements and assignable binary signals.
// ======
module field_model (
   // Clock.
   input wire pclk,
   // Requested pickups and signal levels.
   input wire [7:0] fault,
   input wire [7:0] dig_lvl,
   input wire [7:0] int_lvl,
   input wire dir_lvl,
   // Element outputs and assignment list.
   output logic [7:0] start_in,
   output logic [7:0] trip_in,
   output logic [7:0] digital_in,
   output logic [7:0] internal_sig,
   output logic ground_dir_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   // An element starts on a fault and trips one cycle later.
   // Reset covers the first edges, so no separate start value.
   always @(posedge pclk) begin
      start_in <= fault;
      trip_in <= start_in & fault;
      digital_in <= dig_lvl;
      internal_sig <= int_lvl;
      ground_dir_ok <= dir_lvl;
   end
endmodule

// >>> tb/testbench.sv
`include "blocking_defs.vh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ======
   // Signals and instances.
   // ======
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic dir, ground_dir_ok;
   logic [7:0] paddr, fault, dig, intl, start_in, trip_in;
   logic [7:0] digital_in, internal_sig, start_out, trip_out;
   logic [7:0] module_blocked, trip_blocked;
   logic [31:0] pwdata, prdata;
   int mismatches = 0;
   int samples_checked = 0;
   // Release and element delays of the directional stage.
   localparam int dir_rel = 3;
   localparam int dir_dly = 4;
   // Stages 6 and 7 take no reverse interlock; 7 is directional.
   protection_blocking_logic #(.CURRENT_MASK(8'h3F), .DIR_STAGE(7)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .digital_in(digital_in),
      .internal_sig(internal_sig), .start_in(start_in),
      .trip_in(trip_in), .ground_dir_ok(ground_dir_ok),
      .start_out(start_out), .trip_out(trip_out),
      .module_blocked(module_blocked), .trip_blocked(trip_blocked));
   field_model i_field (.pclk(pclk), .fault(fault), .dig_lvl(dig),
      .int_lvl(intl), .dir_lvl(dir), .start_in(start_in),
      .trip_in(trip_in), .digital_in(digital_in),
      .internal_sig(internal_sig), .ground_dir_ok(ground_dir_ok));
   // Clock of 50 ns.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ======
   // Shared tasks.
   // ======
   // Prints the verdict and ends the run.
   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Compares one value with its expectation.
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer, held until the answer, then an idle cycle.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   // Register read, judged on data and error flag.
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic ex);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check("read data", q, x);
      check("error flag", {31'h0, e}, {31'h0, ex});
   endtask
   // Lets changes settle, then judges all four gated vectors.
   task automatic look(input logic [7:0] mb, tbk, so, to);
      repeat (4) @(posedge pclk);
      check("module_blocked", {24'h0, module_blocked}, {24'h0, mb});
      check("trip_blocked", {24'h0, trip_blocked}, {24'h0, tbk});
      check("start_out", {24'h0, start_out}, {24'h0, so});
      check("trip_out", {24'h0, trip_out}, {24'h0, to});
   endtask
   // ======
   // Scenarios.
   // ======
   // Reset values, a refused address and the read-only status.
   task automatic t_reset();
      rd(`OFS_CTRL, 32'h1, 1'b0);
      rd(`OFS_MOD_EN, 32'h0, 1'b0);
      rd(`OFS_SEL_A, 32'h0, 1'b0);
      rd(8'h2C, 32'h0, 1'b1);
      wr(`OFS_STATUS, 32'h0);
      rd(`OFS_STATUS, 32'hFF, 1'b0);
      look(8'hFF, 8'h00, 8'h00, 8'h00);
   endtask
   // Module enables, then the global switch turned off.
   task automatic t_enable();
      wr(`OFS_MOD_EN, 32'hFF);
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
      wr(`OFS_CTRL, 32'h0);
      look(8'hFF, 8'h00, 8'h00, 8'h00);
      rd(`OFS_STATUS, 32'h100FF, 1'b0);
      wr(`OFS_CTRL, 32'h1);
   endtask
   // Permanent and temporary trip-command blocks.
   task automatic t_trip();
      wr(`OFS_PERM_TRIP, 32'h05);
      look(8'h00, 8'h05, 8'h7F, 8'h7A);
      wr(`OFS_PERM_TRIP, 32'h00);
      wr(`OFS_SEL_A, 32'h01000000);
      dig <= 8'h01;
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
      wr(`OFS_TRIP_PERMIT, 32'h30);
      look(8'h00, 8'h30, 8'h7F, 8'h4F);
      dig <= 8'h00;
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
      wr(`OFS_TRIP_PERMIT, 32'h00);
   endtask
   // Both module slots, their permission and the global block.
   task automatic t_module();
      wr(`OFS_SEL_A, 32'h000A0209);
      rd(`OFS_SEL_A, 32'h000A0209, 1'b0);
      wr(`OFS_EXT_PERMIT, 32'h0F);
      dig <= 8'h02;
      look(8'h0F, 8'h00, 8'h70, 8'h70);
      dig <= 8'h00;
      intl <= 8'h02;
      look(8'h0F, 8'h00, 8'h70, 8'h70);
      intl <= 8'h01;
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
      wr(`OFS_CTRL, 32'h3);
      look(8'hFF, 8'h00, 8'h00, 8'h00);
      intl <= 8'h02;
      wr(`OFS_EXT_PERMIT, 32'h00);
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
      intl <= 8'h00;
      wr(`OFS_CTRL, 32'h1);
   endtask
   // Reverse interlock reaches current stages only.
   task automatic t_reverse();
      wr(`OFS_SEL_B, 32'h10);
      rd(`OFS_SEL_B, 32'h10, 1'b0);
      wr(`OFS_RI_PERMIT, 32'hFF);
      intl <= 8'h80;
      look(8'h3F, 8'h00, 8'h40, 8'h40);
      intl <= 8'h00;
      look(8'h00, 8'h00, 8'h7F, 8'h7F);
   endtask
   // Directional stage waits for release, then its own delay.
   task automatic t_dir();
      int n;
      n = 0;
      wr(`OFS_REL_DELAY, dir_rel);
      wr(`OFS_TRIP_DELAY, dir_dly);
      fault <= 8'h80;
      repeat (20) @(posedge pclk);
      check("unreleased trip", {31'h0, trip_out[7]}, 32'h0);
      dir <= 1'b1;
      // Pickup one edge later, release state the next; the status then shows the release.
      repeat (3) @(posedge pclk);
      rd(`OFS_STATUS, 32'h00020000, 1'b0);
      // Six edges have passed since the direction was released.
      n = 6;
      while (trip_out[7] !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      // Both delays in full, plus the fixed pipeline edges.
      check("delay sum", n, dir_rel + dir_dly + 6);
      fault <= 8'h00;
      dir <= 1'b0;
   endtask
   // ======
   // Main sequence and watchdog.
   // ======
   initial begin
      {psel, penable, pwrite, dir, paddr, pwdata} = 44'h0;
      {fault, dig, intl} = 24'h0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      fault <= 8'h7F;
      @(posedge pclk);
      t_reset();
      t_enable();
      t_trip();
      t_module();
      t_reverse();
      t_dir();
      test_done();
   end
   // Cuts a hang short well beyond the expected run.
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done();
   end
endmodule

bind protection_blocking_logic blocking_assertions #(.N(N)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .start_in(start_in),
   .trip_in(trip_in), .start_out(start_out), .trip_out(trip_out),
   .module_blocked(module_blocked), .trip_blocked(trip_blocked));

// >>> verilog/dir_trip_timer.v
`include "blocking_defs.vh"

// ==========================================================
// Directional ground element trip timer.
// ==========================================================
// The element delay only starts once the direction release
// delay has run out, so the two delays add up.
module dir_trip_timer #(
   parameter CW = 16
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Pickup qualified by direction and by blocking.
   input wire pickup,
   // Delays in clock cycles.
   input wire [CW-1:0] rel_cycles,
   input wire [CW-1:0] trip_cycles,
   // Timer outputs.
   output wire releasing,
   output wire trip
);

   // One-hot states.
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_REL = 4'h2;
   localparam [3:0] S_DLY = 4'h4;
   localparam [3:0] S_TRIP = 4'h8;

   // Current state and shared cycle counter.
   reg [3:0] state;
   reg [CW-1:0] cnt;

   assign releasing = state[1];
   assign trip = state[3];

   // Any loss of pickup drops the timer straight back to idle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         cnt <= {CW{1'b0}};
      end else begin
         case (state)
            S_IDLE: begin
               cnt <= {CW{1'b0}};
               if (pickup) begin
                  state <= S_REL;
               end
            end
            S_REL: begin
               if (!pickup) begin
                  state <= S_IDLE;
               end else if (cnt >= rel_cycles) begin
                  cnt <= {CW{1'b0}};
                  state <= S_DLY;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            S_DLY: begin
               if (!pickup) begin
                  state <= S_IDLE;
               end else if (cnt >= trip_cycles) begin
                  state <= S_TRIP;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            S_TRIP: begin
               if (!pickup) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// >>> verilog/protection_blocking_logic.v
`include "blocking_defs.vh"


// ==========================================================
// Protection blocking logic with an APB register file.
// ==========================================================
module protection_blocking_logic #(
   parameter N = 8,
   parameter NDIG = 8,
   parameter NINT = 8,
   parameter [N-1:0] CURRENT_MASK = 8'hFF,
   parameter DIR_STAGE = 0
) (
   // APB clock and reset.
   input wire pclk,
   input wire presetn,
   // APB request.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   // APB answer.
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Assignment list sources.
   input wire [NDIG-1:0] digital_in,
   input wire [NINT-1:0] internal_sig,
   // Raw outputs of the protection elements.
   input wire [N-1:0] start_in,
   input wire [N-1:0] trip_in,
   input wire ground_dir_ok,
   // Gated outputs toward the breaker and annunciation.
   output reg [N-1:0] start_out,
   output reg [N-1:0] trip_out,
   output reg [N-1:0] module_blocked,
   output reg [N-1:0] trip_blocked
);

   // Size of the assignment list.
   localparam NSRC = NDIG + NINT;

   // ========================================================
   // Configuration registers.
   // ========================================================
   // Global enable and global external block permission.
   reg [1:0] ctrl;
   // Selection codes: global, slot a, slot b, trip, interlock.
   reg [`SEL_W*`SEL_COUNT-1:0] sel_bus;
   // Per-module enable.
   reg [N-1:0] mod_en;
   // Per-module external block permission.
   reg [N-1:0] external_block_permit;
   // Per-stage permanent trip block.
   reg [N-1:0] permanent_trip_block;
   // Per-stage temporary trip block permission.
   reg [N-1:0] trip_block_permit;
   // Per-module reverse interlock permission.
   reg [N-1:0] ri_permit;
   // Direction release delay and element delay, in cycles.
   reg [`DELAY_W-1:0] rel_delay;
   reg [`DELAY_W-1:0] trip_delay;

   // ========================================================
   // Assigned blocking signals.
   // ========================================================
   // Whole assignment list: internal signals above inputs.
   wire [NSRC-1:0] sources;
   // One selected level per selection code.
   wire [`SEL_COUNT-1:0] selected;

   assign sources = {internal_sig, digital_in};

   // One selector per assignable blocking input.
   genvar s;
   generate
      for (s = 0; s < `SEL_COUNT; s = s + 1) begin : g_sel
         signal_selector #(
            .NSRC(NSRC),
            .SELW(`SEL_W)
         ) u_sel (
            .sources(sources),
            .sel(sel_bus[s*`SEL_W +: `SEL_W]),
            .sig(selected[s])
         );
      end
   endgenerate

   // Named views of the selected signals.
   wire global_sig;
   wire block_signal_slot_a;
   wire block_signal_slot_b;
   wire trip_block_signal;
   wire ri_sig;

   assign global_sig = selected[`SEL_IDX_GLOBAL];
   assign block_signal_slot_a = selected[`SEL_IDX_SLOT_A];
   assign block_signal_slot_b = selected[`SEL_IDX_SLOT_B];
   assign trip_block_signal = selected[`SEL_IDX_TRIP];
   assign ri_sig = selected[`SEL_IDX_RI];

   // ========================================================
   // Blocking decisions.
   // ========================================================
   // Whole protection off or blocked.
   wire global_off;
   wire global_block;
   // Either slot asserted.
   wire slot_block;
   // Per-stage effective module and trip blocks.
   wire [N-1:0] next_module_blocked;
   wire [N-1:0] next_trip_blocked;
   // Trip request after the directional timer substitution.
   wire [N-1:0] trip_req;

   assign global_off = ~ctrl[`CTRL_GLOBAL_EN];
   // The global block follows its signal level while the global permission bit is set.
   assign global_block = ctrl[`CTRL_GLOBAL_PERMIT] & global_sig;
   assign slot_block = block_signal_slot_a | block_signal_slot_b;

   // Per-stage block terms, evaluated every cycle.
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_stage
         // Reverse interlock only reaches current modules.
         wire ri_term;
         assign ri_term = CURRENT_MASK[i] & ri_permit[i]
            & ri_sig;
         // Disable, global and permitted temporary blocks OR'd.
         assign next_module_blocked[i] = global_off | global_block
            | ~mod_en[i]
            | (external_block_permit[i] & slot_block)
            | ri_term;
         // Permanent block or permitted temporary signal.
         assign next_trip_blocked[i] = permanent_trip_block[i]
            | (trip_block_permit[i] & trip_block_signal);
      end
   endgenerate

   // ========================================================
   // Directional ground element timing.
   // ========================================================
   // Pickup of the directional stage, gated by its block.
   wire dir_pickup;
   wire dir_trip;
   wire dir_releasing;

   assign dir_pickup = start_in[DIR_STAGE] & ground_dir_ok
      & ~next_module_blocked[DIR_STAGE];

   // The timer runs the release delay and then the own delay.
   dir_trip_timer #(
      .CW(`DELAY_W)
   ) u_dir (
      .pclk(pclk),
      .presetn(presetn),
      .pickup(dir_pickup),
      .rel_cycles(rel_delay),
      .trip_cycles(trip_delay),
      .releasing(dir_releasing),
      .trip(dir_trip)
   );

   // The directional stage trips only when its timer and its raw trip are both set.
   generate
      for (i = 0; i < N; i = i + 1) begin : g_req
         if (i == DIR_STAGE) begin : g_dir
            assign trip_req[i] = dir_trip & trip_in[i];
         end else begin : g_plain
            assign trip_req[i] = trip_in[i];
         end
      end
   endgenerate

   // ========================================================
   // Gated outputs.
   // ========================================================
   // A blocked module neither starts nor trips; a blocked
   // trip command still lets the start through.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_out <= {N{1'b0}};
         trip_out <= {N{1'b0}};
         module_blocked <= {N{1'b1}};
         trip_blocked <= {N{1'b0}};
      end else begin
         start_out <= start_in & ~next_module_blocked;
         trip_out <= trip_req & ~next_module_blocked
            & ~next_trip_blocked;
         module_blocked <= next_module_blocked;
         trip_blocked <= next_trip_blocked;
      end
   end

   // ========================================================
   // APB slave.
   // ========================================================
   // Setup phase seen, so the answer is due next cycle.
   wire setup;
   // Access phase completing at this edge.
   wire access;
   // Address matches a mapped register.
   reg mapped;
   // Read value for the addressed register.
   reg [31:0] next_rdata;
   // Status word built from the block's own state.
   wire [31:0] status;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready;

   assign status = {{(32 - `STAT_TIMER_POS - 1){1'b0}},
      dir_releasing, global_block | global_off,
      {(8 - N){1'b0}}, trip_blocked,
      {(8 - N){1'b0}}, module_blocked};

   // Address decode and read multiplexer.
   always @* begin
      mapped = 1'b1;
      next_rdata = 32'h00000000;
      case (paddr)
         `OFS_CTRL: begin
            next_rdata = {30'h00000000, ctrl};
         end
         `OFS_SEL_A: begin
            next_rdata = {3'h0, sel_bus[19:15], 3'h0, sel_bus[14:10],
               3'h0, sel_bus[9:5], 3'h0, sel_bus[4:0]};
         end
         `OFS_SEL_B: begin
            next_rdata = {27'h0000000, sel_bus[24:20]};
         end
         `OFS_MOD_EN: begin
            next_rdata = {{(32 - N){1'b0}}, mod_en};
         end
         `OFS_EXT_PERMIT: begin
            next_rdata = {{(32 - N){1'b0}}, external_block_permit};
         end
         `OFS_PERM_TRIP: begin
            next_rdata = {{(32 - N){1'b0}}, permanent_trip_block};
         end
         `OFS_TRIP_PERMIT: begin
            next_rdata = {{(32 - N){1'b0}}, trip_block_permit};
         end
         `OFS_RI_PERMIT: begin
            next_rdata = {{(32 - N){1'b0}}, ri_permit};
         end
         `OFS_REL_DELAY: begin
            next_rdata = {16'h0000, rel_delay};
         end
         `OFS_TRIP_DELAY: begin
            next_rdata = {16'h0000, trip_delay};
         end
         `OFS_STATUS: begin
            next_rdata = status;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Answer one cycle after setup: ready, data and error.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= pwrite ? 32'h00000000 : next_rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Register writes take effect at the completing edge only.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         sel_bus <= {`SEL_COUNT{`SEL_RESET}};
         mod_en <= {N{1'b0}};
         external_block_permit <= {N{1'b0}};
         permanent_trip_block <= {N{1'b0}};
         trip_block_permit <= {N{1'b0}};
         ri_permit <= {N{1'b0}};
         rel_delay <= `DELAY_RESET;
         trip_delay <= `DELAY_RESET;
      end else if (access && pwrite) begin
         case (paddr)
            `OFS_CTRL: begin
               ctrl <= pwdata[1:0];
            end
            `OFS_SEL_A: begin
               sel_bus[4:0] <= pwdata[4:0];
               sel_bus[9:5] <= pwdata[12:8];
               sel_bus[14:10] <= pwdata[20:16];
               sel_bus[19:15] <= pwdata[28:24];
            end
            `OFS_SEL_B: begin
               sel_bus[24:20] <= pwdata[4:0];
            end
            `OFS_MOD_EN: begin
               mod_en <= pwdata[N-1:0];
            end
            `OFS_EXT_PERMIT: begin
               external_block_permit <= pwdata[N-1:0];
            end
            `OFS_PERM_TRIP: begin
               permanent_trip_block <= pwdata[N-1:0];
            end
            `OFS_TRIP_PERMIT: begin
               trip_block_permit <= pwdata[N-1:0];
            end
            `OFS_RI_PERMIT: begin
               ri_permit <= pwdata[N-1:0];
            end
            `OFS_REL_DELAY: begin
               rel_delay <= pwdata[15:0];
            end
            `OFS_TRIP_DELAY: begin
               trip_delay <= pwdata[15:0];
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

endmodule

// >>> verilog/signal_selector.v
// ==========================================================
// Assignment list selector.
// ==========================================================
// Picks one signal from the assignment list; code zero means
// that nothing is assigned, and so does a code past the end.
module signal_selector #(
   parameter NSRC = 16,
   parameter SELW = 5
) (
   // Assignment list and selection code.
   input wire [NSRC-1:0] sources,
   input wire [SELW-1:0] sel,
   // Selected signal.
   output reg sig
);

   // Index into the list, one below the code.
   integer idx;

   // Plain multiplexer with an unassigned state.
   always @* begin
      idx = 0;
      sig = 1'b0;
      if (sel != {SELW{1'b0}}) begin
         idx = sel - 1;
         if (idx < NSRC) begin
            sig = sources[idx];
         end
      end
   end

endmodule
